// ### pscr_pkg.sv
// shared constants for the pll scan chain reconfiguration ends
package pscr_pkg;
  // ----------------------------------------------------------------
  // scan chain layout
  // ----------------------------------------------------------------
  localparam int CHAIN_LEN  = 144;
  localparam int CNT_BITS   = 18;
  localparam int NUM_CNT    = 7;
  localparam int NUM_POST   = 5;
  localparam int CP_BASE    = 126;
  localparam int LF_BASE    = 135;
  localparam int CP_W       = 3;
  localparam int LFR_W      = 5;
  localparam int LFC_W      = 2;
  localparam int LFC_POS    = 7;
  // counter field: low count, odd bit, high count, bypass bit
  localparam int FLD_LOW    = 0;
  localparam int FLD_ODD    = 8;
  localparam int FLD_HIGH   = 9;
  localparam int FLD_BYP    = 17;
  localparam int HALF_W     = 10;
  localparam int IDX_M      = 5;
  localparam int TAP_W      = 3;
  localparam logic [CNT_BITS-1:0] CNT_RST = 18'h20000;
  localparam logic [CP_W-1:0]     CP_RST  = 3'h0;
  localparam logic [LFR_W-1:0]    LFR_RST = 5'h00;
  localparam logic [LFC_W-1:0]    LFC_RST = 2'h0;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint SYS_HZ      = 50000000;
  localparam longint SCAN_MAX_HZ = 100000000;
  localparam longint SCAN_HZ     = 12500000;
  localparam int     SCAN_DIV    = int'((SYS_HZ + SCAN_HZ - 1) / SCAN_HZ);
  localparam int     DIV_W       = 3;
  localparam int     RST_TICKS   = 2;
  // ----------------------------------------------------------------
  // controller register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int          ADDR_W    = 8;
  localparam int          NUM_WORDS = 5;
  localparam logic [7:0]  A_IMG0    = 8'h00;
  localparam logic [7:0]  A_CTRL    = 8'h14;
  localparam logic [7:0]  A_STAT    = 8'h18;
  localparam int          CTRL_GO   = 0;
  localparam int          ST_BUSY   = 0;
  localparam int          ST_DONE   = 1;
  localparam int          ST_SDONE  = 2;
endpackage

// ### pscr_if.sv
// link between the reconfiguration controller and the pll scan port
interface pscr_if;
  logic scan_tick;
  logic shift_ena;
  logic scan_data;
  logic apply_cfg;
  logic update_busy;

  modport dev (input scan_tick, input shift_ena, input scan_data, input apply_cfg, output update_busy);
  modport ctl (output scan_tick, output shift_ena, output scan_data, output apply_cfg, input update_busy);
endinterface

// ### pscr_cdiv.sv
// one pll divide counter with high/low, bypass and odd-duty settings
module pscr_cdiv (
  // clock and reset
  input  wire logic                            CLK,
  input  wire logic                            SRST,
  // setting load
  input  wire logic                            load_req,
  input  wire logic [pscr_pkg::CNT_BITS-1:0]   load_cfg,
  output logic                                 loaded,
  // divided output
  output logic                                 div_out
);
  typedef struct packed {
    logic [pscr_pkg::CNT_BITS-1:0] cur;
    logic [pscr_pkg::CNT_BITS-1:0] pend;
    logic                          pend_v;
    logic [pscr_pkg::HALF_W-1:0]   cnt;
    logic                          lvl;
    logic                          ld;
  } pscr_cdiv_s;

  pscr_cdiv_s st_reg;
  pscr_cdiv_s st_next;

  // half vco periods of one phase; a zero count stands for 256
  function automatic logic [pscr_pkg::HALF_W-1:0] half_len(input logic [pscr_pkg::CNT_BITS-1:0] c,
                                                          input logic hi);
    logic [8:0]                  n;
    logic [pscr_pkg::HALF_W-1:0] h;
    // high, low, odd and bypass fields
    n = hi ? {c[pscr_pkg::FLD_HIGH+7:pscr_pkg::FLD_HIGH] == 8'h00, c[pscr_pkg::FLD_HIGH+7:pscr_pkg::FLD_HIGH]}
           : {c[pscr_pkg::FLD_LOW+7:pscr_pkg::FLD_LOW] == 8'h00, c[pscr_pkg::FLD_LOW+7:pscr_pkg::FLD_LOW]};
    h = {n, 1'b0};
    if (c[pscr_pkg::FLD_ODD]) begin
      h = hi ? h - 10'h001 : h + 10'h001;
    end
    if (c[pscr_pkg::FLD_BYP]) begin
      h = 10'h001;
    end
    return h;
  endfunction

  always_comb begin
    st_next    = st_reg;
    st_next.ld = 1'b0;
    if (load_req) begin
      st_next.pend   = load_cfg;
      st_next.pend_v = 1'b1;
    end
    if (st_reg.cnt > 10'h001) begin
      st_next.cnt = st_reg.cnt - 10'h001;
    end else if (st_reg.lvl) begin
      st_next.lvl = 1'b0;
      st_next.cnt = half_len(st_reg.cur, 1'b0);
    end else begin
      if (st_reg.pend_v && !load_req) begin
        st_next.cur    = st_reg.pend;
        st_next.pend_v = 1'b0;
        st_next.ld     = 1'b1;
        st_next.cnt    = half_len(st_reg.pend, 1'b1);
      end else begin
        st_next.cnt = half_len(st_reg.cur, 1'b1);
      end
      st_next.lvl = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      st_reg <= '{cur: pscr_pkg::CNT_RST, pend: pscr_pkg::CNT_RST, pend_v: 1'b0,
                  cnt: 10'h001, lvl: 1'b0, ld: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign loaded  = st_reg.ld;
  assign div_out = st_reg.lvl;
endmodule

// ### pscr_dev.sv
// pll scan chain and configuration store, device end
module pscr_dev (
  // clock and reset
  input  wire logic                                      CLK,
  input  wire logic                                      SRST,
  // scan link
  pscr_if.dev                                            lnk,
  // phase step request
  input  wire logic                                      PHASE_STEP,
  input  wire logic                                      PHASE_UP,
  input  wire logic [2:0]                                PHASE_SEL,
  output logic                                           PHASE_DONE,
  output logic [pscr_pkg::NUM_CNT*pscr_pkg::TAP_W-1:0]   PHASE_TAP,
  // applied settings
  output logic [pscr_pkg::NUM_CNT-1:0]                   COUNTER_CLK,
  output logic [pscr_pkg::CP_W-1:0]                      PUMP_CURRENT_CODE,
  output logic [pscr_pkg::LFR_W-1:0]                     FILTER_RESISTOR_CODE,
  output logic [pscr_pkg::LFC_W-1:0]                     FILTER_CAPACITOR_CODE,
  output logic                                           CODE_ERR
);
  typedef struct packed {
    logic [pscr_pkg::CHAIN_LEN-1:0]                    chain;
    logic [1:0]                                        ena_ticks;
    logic                                              busy;
    logic [pscr_pkg::NUM_CNT-1:0]                      wait_mask;
    logic                                              load;
    logic [pscr_pkg::CP_W-1:0]                         cp;
    logic [pscr_pkg::LFR_W-1:0]                        filter_resistor_code;
    logic [pscr_pkg::LFC_W-1:0]                        filter_capacitor_code;
    logic                                              err;
    logic [pscr_pkg::NUM_CNT*pscr_pkg::TAP_W-1:0]      taps;
    logic                                              step_prev;
    logic                                              pdone;
  } pscr_dev_s;

  pscr_dev_s                    st_reg;
  pscr_dev_s                    st_next;
  logic [pscr_pkg::NUM_CNT-1:0] cnt_loaded;
  logic [pscr_pkg::NUM_CNT-1:0] cnt_out;

  // --------------------------------------------------------------
  // chain field decoding
  // --------------------------------------------------------------
  // counter positions in chain
  function automatic int cnt_base(input int i);
    return (i < pscr_pkg::NUM_POST) ? (pscr_pkg::NUM_POST - 1 - i) * pscr_pkg::CNT_BITS : i * pscr_pkg::CNT_BITS;
  endfunction

  function automatic logic cp_ok(input logic [pscr_pkg::CP_W-1:0] c);
    return (c == 3'h0) || (c == 3'h4) || (c == 3'h6) || (c == 3'h7);
  endfunction

  function automatic logic lfr_ok(input logic [pscr_pkg::LFR_W-1:0] c);
    return (c[1:0] == 2'h0 && c[2] == 1'b0) || ((c[1:0] == 2'h3 || c[2]) && !(c[2] && c[1:0] != 2'h0))
           ? (c[3:0] != 4'hC || c[4]) && (c[3:0] != 4'hB || c[4]) && (c != 5'h0B) && (c != 5'h0C)
             && !(c[3] && !c[4] && c[2:0] != 3'h0)
           : (c == 5'h1E);
  endfunction

  function automatic logic lfc_ok(input logic [pscr_pkg::LFC_W-1:0] c);
    return c != 2'h2;
  endfunction

  // --------------------------------------------------------------
  // divide counters
  // --------------------------------------------------------------
  for (genvar g = 0; g < pscr_pkg::NUM_CNT; g++) begin : g_cnt
    pscr_cdiv u_cdiv (
      .CLK      (CLK),
      .SRST     (SRST),
      .load_req (st_reg.load),
      .load_cfg (st_reg.chain[cnt_base(g) +: pscr_pkg::CNT_BITS]),
      .loaded   (cnt_loaded[g]),
      .div_out  (cnt_out[g])
    );
  end

  // --------------------------------------------------------------
  // scan, apply and phase step
  // --------------------------------------------------------------
  always_comb begin
    logic [pscr_pkg::CP_W-1:0]  ncp;
    logic [pscr_pkg::LFR_W-1:0] nlfr;
    logic [pscr_pkg::LFC_W-1:0] nlfc;
    logic [pscr_pkg::TAP_W-1:0] t;
    ncp     = st_reg.chain[pscr_pkg::CP_BASE +: pscr_pkg::CP_W];
    nlfr    = st_reg.chain[pscr_pkg::LF_BASE +: pscr_pkg::LFR_W];
    nlfc    = st_reg.chain[pscr_pkg::LF_BASE + pscr_pkg::LFC_POS +: pscr_pkg::LFC_W];
    t       = '0;
    st_next = st_reg;
    st_next.load = 1'b0;
    // busy flag tracks counters
    // cleared here so that an apply in the same cycle wins
    if (st_reg.busy && !st_reg.load) begin
      st_next.wait_mask = st_reg.wait_mask & ~cnt_loaded;
      if ((st_reg.wait_mask & ~cnt_loaded) == '0) begin
        st_next.busy = 1'b0;
      end
    end
    if (lnk.scan_tick) begin
      st_next.pdone     = 1'b1;
      st_next.step_prev = PHASE_STEP;
      if (!lnk.shift_ena) begin
        st_next.ena_ticks = 2'h0;
      end else if (st_reg.ena_ticks != 2'h2) begin
        st_next.ena_ticks = st_reg.ena_ticks + 2'h1;
      end
      if (lnk.shift_ena && st_reg.ena_ticks != 2'h0) begin
        st_next.chain = {lnk.scan_data, st_reg.chain[pscr_pkg::CHAIN_LEN-1:1]};
      end
      if (lnk.apply_cfg) begin
        st_next.load      = 1'b1;
        st_next.busy      = 1'b1;
        st_next.wait_mask = '1;
        // illegal analog codes keep the old value so the loop never sees them
        st_next.err = !(cp_ok(ncp) && lfr_ok(nlfr) && lfc_ok(nlfc));
        if (cp_ok(ncp)) begin
          st_next.cp = ncp;
        end
        if (lfr_ok(nlfr)) begin
          st_next.filter_resistor_code = nlfr;
        end
        if (lfc_ok(nlfc)) begin
          st_next.filter_capacitor_code = nlfc;
        end
      end
      if (PHASE_STEP && !st_reg.step_prev) begin
        st_next.pdone = 1'b0;
        for (int i = 0; i <= pscr_pkg::IDX_M; i++) begin
          if ((PHASE_SEL == 3'h0 && i < pscr_pkg::NUM_POST) || (PHASE_SEL == 3'h1 && i == pscr_pkg::IDX_M)
              || (int'(PHASE_SEL) == i + 2)) begin
            t = st_reg.taps[i*pscr_pkg::TAP_W +: pscr_pkg::TAP_W];
            st_next.taps[i*pscr_pkg::TAP_W +: pscr_pkg::TAP_W] = PHASE_UP ? t + 3'h1 : t - 3'h1;
          end
        end
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      st_reg <= '{chain: '0, ena_ticks: 2'h0, busy: 1'b0, wait_mask: '0, load: 1'b0,
                  cp: pscr_pkg::CP_RST, filter_resistor_code: pscr_pkg::LFR_RST, filter_capacitor_code: pscr_pkg::LFC_RST,
                  err: 1'b0, taps: '0, step_prev: 1'b0, pdone: 1'b1};
    end else begin
      st_reg <= st_next;
    end
  end

  assign lnk.update_busy          = st_reg.busy;
  assign PHASE_DONE               = st_reg.pdone;
  assign PHASE_TAP                = st_reg.taps;
  assign COUNTER_CLK              = cnt_out;
  assign PUMP_CURRENT_CODE        = st_reg.cp;
  assign FILTER_RESISTOR_CODE     = st_reg.filter_resistor_code;
  assign FILTER_CAPACITOR_CODE    = st_reg.filter_capacitor_code;
  assign CODE_ERR                 = st_reg.err;
endmodule

// ### pscr_ctl.sv
// reconfiguration controller, core logic end of the scan link
module pscr_ctl (
  // clock and reset
  input  wire logic                          CLK,
  input  wire logic                          SRST,
  // software port
  input  wire logic [pscr_pkg::ADDR_W-1:0]   ADDR,
  input  wire logic [31:0]                   WDATA,
  input  wire logic                          WR,
  input  wire logic                          RD,
  output logic [31:0]                        RDATA,
  // pll asynchronous reset request
  output logic                               PLL_RESET,
  // scan link
  pscr_if.ctl                                lnk
);
  localparam int DW = pscr_pkg::DIV_W;

  typedef enum logic [2:0] {S_IDLE, S_ARM, S_SHIFT, S_APPLY, S_WAIT_HI, S_WAIT_LO, S_RESET} pscr_st_e;

  typedef struct packed {
    logic [pscr_pkg::NUM_WORDS*32-1:0] img;
    pscr_st_e                          fsm;
    logic [DW-1:0]                     div;
    logic                              tick;
    logic [7:0]                        idx;
    logic                              ena;
    logic                              sdat;
    logic                              upd;
    logic                              prst;
    logic                              done;
    logic [31:0]                       rdata;
  } pscr_ctl_s;

  pscr_ctl_s st_reg;
  pscr_ctl_s st_next;

  always_comb begin
    logic go;
    go      = WR && ADDR == pscr_pkg::A_CTRL && WDATA[pscr_pkg::CTRL_GO];
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.div == DW'(pscr_pkg::SCAN_DIV - 1)) begin
      st_next.div  = '0;
      st_next.tick = 1'b1;
    end else begin
      st_next.div = st_reg.div + DW'(1);
    end
    // image words only writable while idle
    if (WR && st_reg.fsm == S_IDLE && ADDR < pscr_pkg::A_CTRL && ADDR[1:0] == 2'h0) begin
      st_next.img[ADDR[pscr_pkg::ADDR_W-1:2]*32 +: 32] = WDATA;
    end
    if (WR && ADDR == pscr_pkg::A_STAT && WDATA[pscr_pkg::ST_DONE]) begin
      st_next.done = 1'b0;
    end
    st_next.rdata = '0;
    if (RD) begin
      if (ADDR < pscr_pkg::A_CTRL && ADDR[1:0] == 2'h0) begin
        st_next.rdata = st_reg.img[ADDR[pscr_pkg::ADDR_W-1:2]*32 +: 32];
      end else if (ADDR == pscr_pkg::A_STAT) begin
        st_next.rdata[pscr_pkg::ST_BUSY]  = st_reg.fsm != S_IDLE;
        st_next.rdata[pscr_pkg::ST_DONE]  = st_reg.done;
        st_next.rdata[pscr_pkg::ST_SDONE] = lnk.update_busy;
      end
    end
    unique case (st_reg.fsm)
      S_IDLE: begin
        if (go) begin
          st_next.fsm = S_ARM;
        end
      end
      S_ARM: begin
        if (st_reg.tick) begin
          st_next.ena  = 1'b1;
          st_next.idx  = '0;
          st_next.sdat = st_reg.img[0];
          st_next.fsm  = S_SHIFT;
        end
      end
      S_SHIFT: begin
        if (st_reg.tick) begin
          if (st_reg.idx == 8'(pscr_pkg::CHAIN_LEN)) begin
            st_next.ena = 1'b0;
            st_next.fsm = S_APPLY;
          end else begin
            st_next.idx  = st_reg.idx + 8'h01;
            st_next.sdat = st_reg.img[st_reg.idx];
          end
        end
      end
      S_APPLY: begin
        if (st_reg.tick) begin
          st_next.upd = !st_reg.upd;
          if (st_reg.upd) begin
            st_next.fsm = S_WAIT_HI;
          end
        end
      end
      S_WAIT_HI: begin
        if (lnk.update_busy) begin
          st_next.fsm = S_WAIT_LO;
        end
      end
      S_WAIT_LO: begin
        if (!lnk.update_busy && st_reg.tick) begin
          st_next.prst = 1'b1;
          st_next.idx  = '0;
          st_next.fsm  = S_RESET;
        end
      end
      S_RESET: begin
        if (st_reg.tick) begin
          st_next.idx = st_reg.idx + 8'h01;
          if (st_reg.idx == 8'(pscr_pkg::RST_TICKS - 1)) begin
            st_next.prst = 1'b0;
            st_next.done = 1'b1;
            st_next.fsm  = S_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      st_reg <= '{img: '0, fsm: S_IDLE, div: '0, tick: 1'b0, idx: 8'h00, ena: 1'b0,
                  sdat: 1'b0, upd: 1'b0, prst: 1'b0, done: 1'b0, rdata: 32'h00000000};
    end else begin
      st_reg <= st_next;
    end
  end

  assign lnk.scan_tick = st_reg.tick;
  assign lnk.shift_ena = st_reg.ena;
  assign lnk.scan_data = st_reg.sdat;
  assign lnk.apply_cfg = st_reg.upd;
  assign PLL_RESET     = st_reg.prst;
  assign RDATA         = st_reg.rdata;
endmodule

// ### pscr_assertions.sv
// protocol checks on the scan link between controller and device
module pscr_assertions (
  // clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // scan link
  input wire logic scan_tick,
  input wire logic shift_ena,
  input wire logic scan_data,
  input wire logic apply_cfg,
  input wire logic update_busy
);
  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  localparam int ENA_TICKS = 145;
  logic [7:0] ena_cnt_reg;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  // ticks seen while enable stands; the first one is skipped by the chain
  always_ff @(posedge CLK) begin
    if (SRST || !shift_ena) begin
      ena_cnt_reg <= 8'h00;
    end else if (scan_tick) begin
      ena_cnt_reg <= ena_cnt_reg + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_tick_gap;
    scan_tick |=> !scan_tick [*3];
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("shift tick repeated too soon");

  property p_tick_period;
    scan_tick |-> ##4 scan_tick;
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("shift tick period is not four cycles");

  property p_ena_move;
    !$stable(shift_ena) |-> $past(scan_tick);
  endproperty
  a_ena_move: assert property (p_ena_move)
    else $error("shift enable moved away from a tick");

  property p_data_move;
    !$stable(scan_data) |-> $past(scan_tick);
  endproperty
  a_data_move: assert property (p_data_move)
    else $error("serial data moved away from a tick");

  property p_ena_len;
    $fell(shift_ena) |-> ena_cnt_reg == ENA_TICKS;
  endproperty
  a_ena_len: assert property (p_ena_len)
    else $error("shift phase did not hold all chain bits");

  property p_apply_idle;
    apply_cfg |-> !shift_ena;
  endproperty
  a_apply_idle: assert property (p_apply_idle)
    else $error("apply strobe while shifting");

  property p_apply_len;
    $rose(apply_cfg) |-> apply_cfg [*4] ##1 !apply_cfg;
  endproperty
  a_apply_len: assert property (p_apply_len)
    else $error("apply strobe is not one tick period");

  property p_busy_rise;
    scan_tick && apply_cfg |=> update_busy;
  endproperty
  a_busy_rise: assert property (p_busy_rise)
    else $error("update flag did not rise on apply");

  property p_busy_cause;
    $rose(update_busy) |-> $past(apply_cfg) && $past(scan_tick);
  endproperty
  a_busy_cause: assert property (p_busy_cause)
    else $error("update flag rose without apply");
endmodule

// ### testbench.sv
// self-checking bench joining the controller and the device over the scan link
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        ph_step = 1'b0;
  logic        ph_up = 1'b0;
  logic [2:0]  ph_sel = 3'h0;
  logic [31:0] rdata, rv;
  logic        pll_rst, ph_done, code_err;
  logic [20:0] ph_tap;
  logic [6:0]  cclk;
  logic [2:0]  cp;
  logic [4:0]  filter_resistor_code;
  logic [1:0]  filter_capacitor_code;
  logic [15:0] hi, lo;
  logic [159:0] img;
  int          n_fail = 0;
  int          n_tests = 0;
  int          n_rst = 0;
  // pump, resistor, capacitor codes packed 3/5/2
  localparam logic [9:0] ROWS [11] = '{10'h000, 10'h20D, 10'h313, 10'h3A0, 10'h041, 10'h24F,
                                       10'h350, 10'h3E1, 10'h06F, 10'h270, 10'h379};

  pscr_if lnk_if ();
  pscr_ctl pscr_ctl_inst (.CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .PLL_RESET(pll_rst), .lnk(lnk_if));
  pscr_dev pscr_dev_inst (.CLK(clk), .SRST(srst), .lnk(lnk_if), .PHASE_STEP(ph_step), .PHASE_UP(ph_up),
    .PHASE_SEL(ph_sel), .PHASE_DONE(ph_done), .PHASE_TAP(ph_tap), .COUNTER_CLK(cclk),
    .PUMP_CURRENT_CODE(cp), .FILTER_RESISTOR_CODE(filter_resistor_code), .FILTER_CAPACITOR_CODE(filter_capacitor_code), .CODE_ERR(code_err));
  pscr_assertions pscr_assertions_inst (.CLK(clk), .SRST(srst), .scan_tick(lnk_if.scan_tick),
    .shift_ena(lnk_if.shift_ena), .scan_data(lnk_if.scan_data), .apply_cfg(lnk_if.apply_cfg),
    .update_busy(lnk_if.update_busy));

  always #10 clk = ~clk;
  always @(posedge clk) begin
    if (pll_rst === 1'b1) n_rst++;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  // c4 odd 2/1 at the chain head, c3 plain 2/1, c0 bypassed over junk
  task automatic load(input logic [9:0] r);
    img = '0;
    for (int c = 0; c < 7; c++) img[c * 18 +: 18] = pscr_pkg::CNT_RST;
    img[17:0] = {1'b0, 8'h02, 1'b1, 8'h01};
    img[35:18] = {1'b0, 8'h02, 1'b0, 8'h01};
    img[89:72] = 18'h3FFFF;
    img[128:126] = r[9:7];
    img[139:135] = r[6:2];
    img[143:142] = r[1:0];
    for (int w = 0; w < 5; w++) wr_reg(8'(4 * w), img[32 * w +: 32]);
  endtask
  task automatic go();
    int k;
    int r0;
    k = 0;
    r0 = n_rst;
    rv = '0;
    wr_reg(pscr_pkg::A_CTRL, 32'h1);
    while (rv[1] !== 1'b1 && k < 2000) begin
      rd_reg(pscr_pkg::A_STAT, rv);
      k++;
    end
    chk(rv, 32'h2);
    wr_reg(pscr_pkg::A_STAT, 32'h2);
    chk(32'(n_rst - r0), 32'h8);
  endtask
  // high and low time of one divided output, in clock cycles
  task automatic meas(input int i);
    int k;
    k = 0;
    hi = '0;
    lo = '0;
    @(negedge clk);
    while (cclk[i] !== 1'b0 && k < 600) begin @(negedge clk); k++; end
    while (cclk[i] !== 1'b1 && k < 1200) begin @(negedge clk); k++; end
    while (cclk[i] === 1'b1 && hi < 600) begin @(negedge clk); hi++; end
    while (cclk[i] === 1'b0 && lo < 600) begin @(negedge clk); lo++; end
  endtask
  task automatic step(input logic [2:0] s);
    int k;
    k = 0;
    @(posedge clk);
    ph_sel <= s;
    ph_up <= 1'b1;
    ph_step <= 1'b1;
    while (ph_done !== 1'b0 && k < 100) begin @(negedge clk); k++; end
    @(posedge clk);
    ph_step <= 1'b0;
    while (ph_done !== 1'b1 && k < 200) begin @(negedge clk); k++; end
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk(32'({cp, filter_resistor_code, filter_capacitor_code, code_err, ph_done}), 32'h1);
    chk(32'(ph_tap), 32'h0);
    wr_reg(8'h1C, 32'hFFFFFFFF);
    rd_reg(8'h1C, rv);
    chk(rv, 32'h0);
    meas(0);
    chk({hi, lo}, 32'h00010001);
    foreach (ROWS[i]) begin
      load(ROWS[i]);
      go();
      chk(32'({cp, filter_resistor_code, filter_capacitor_code, code_err}), 32'({ROWS[i], 1'b0}));
    end
    meas(4);
    chk({hi, lo}, 32'h00030003);
    meas(3);
    chk({hi, lo}, 32'h00040002);
    meas(0);
    chk({hi, lo}, 32'h00010001);
    step(3'h2);
    chk(32'(ph_tap), 32'h1);
    step(3'h1);
    chk(32'(ph_tap), 32'h8001);
    step(3'h0);
    chk(32'(ph_tap), 32'h924A);
    // illegal codes everywhere; held until the strobe, then refused
    load(10'h106);
    chk(32'({cp, filter_resistor_code, filter_capacitor_code, code_err}), 32'({10'h379, 1'b0}));
    go();
    chk(32'({cp, filter_resistor_code, filter_capacitor_code, code_err}), 32'({10'h379, 1'b1}));
    chk(32'(ph_tap), 32'h924A);
    load(ROWS[5]);
    go();
    chk(32'({cp, filter_resistor_code, filter_capacitor_code, code_err}), 32'({ROWS[5], 1'b0}));
    // reset in the middle of a shift must leave nothing applied
    wr_reg(pscr_pkg::A_CTRL, 32'h1);
    repeat (200) @(posedge clk);
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk(32'({cp, filter_resistor_code, filter_capacitor_code, code_err, ph_done}), 32'h1);
    rd_reg(pscr_pkg::A_STAT, rv);
    chk(rv, 32'h0);
    give_verdict();
  end

  // hang guard, well past the expected run length
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    give_verdict();
  end
endmodule
